// [clrq_engine.v]
// command list ring queue engine, adapter side
// assumes a simple memory master: one request at a time, memAck pulse ends it
// Operation
// - header is 32 bytes, four indexes
// - status count at 14H, at most 4096
// - command ring starts at 20H, contiguous
// - adapter never writes command producer index
// - adapter advances command consumer after fetch
// - adapter advances status producer per deposit
// - adapter never writes status consumer index
// - command entry 28 bytes, count max 2340
// - status entry 16 bytes, max 4096
// - status ring follows last command entry
// - command ring is its own circular list
// - status ring is a separate circular list
// - several status entries per command allowed
// - empty when equal, full at consumer-1
// - indexes are entry numbers, not bytes
// - consumer index update may be deferred
`timescale 1ns/1ps
`include "clrq_regs.vh"
module clrq_engine (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        startQueue,
    input  wire [31:0] queueBase,
    input  wire        attnWrite,
    input  wire [31:0] attnData,
    output reg         memReq_ff,
    output reg         memWrite_ff,
    output reg  [31:0] memAddr_ff,
    output reg  [31:0] memWdata_ff,
    input  wire [31:0] memRdata,
    input  wire        memAck,
    output reg  [31:0] cmdWord_ff,
    output reg         cmdValid_ff,
    output reg         cmdLast_ff,
    input  wire        cmdReady,
    input  wire [31:0] stsWord,
    input  wire        stsValid,
    output reg         stsReady_ff,
    output reg         busy_ff,
    output reg         stsFull_ff,
    output reg         cfgError_ff
);
    localparam S_IDLE   = 8'h01;
    localparam S_CFG    = 8'h02;
    localparam S_PROD   = 8'h04;
    localparam S_FETCH  = 8'h08;
    localparam S_CONS   = 8'h10;
    localparam S_STSCON = 8'h20;
    localparam S_STSWR  = 8'h40;
    localparam S_STSIDX = 8'h80;

    reg [7:0]  state_ff;
    reg [7:0]  nxt_state;
    reg [31:0] base_ff;
    reg [15:0] cmdCount_ff;
    reg [15:0] stsCount_ff;
    reg [15:0] cmdProd_ff;
    reg [15:0] cmdCons_ff;
    reg [15:0] stsProd_ff;
    reg [15:0] stsCons_ff;
    reg [2:0]  word_ff;
    reg        cfgStep_ff;
    reg        pending_ff;
    reg        running_ff;
    reg [31:0] stsBuf_ff [0:3];
    reg [2:0]  stsFill_ff;
    reg [5:0]  fifoLevel_ff;
    reg [2:0]  outBeat_ff;

    wire [31:0] fifoData;
    wire        fifoValid;
    wire        fifoInReady;
    wire        fifoPush = (state_ff == S_FETCH) && memAck;
    wire        fifoPop  = fifoValid && (!cmdValid_ff || cmdReady);

    function [15:0] wrapInc;
        input [15:0] idx;
        input [15:0] cnt;
        begin
            wrapInc = (idx + 16'h0001 >= cnt) ? 16'h0000 : idx + 16'h0001;
        end
    endfunction

    function [31:0] entryAddr;
        input [15:0] idx;
        input [31:0] size;
        input [31:0] ringBase;
        begin
            entryAddr = ringBase + ({16'h0000, idx} * size);
        end
    endfunction

    wire [31:0] cmdRing = base_ff + `CLRQ_CMD_RING_OFF;
    wire [31:0] stsRing = cmdRing + ({16'h0000, cmdCount_ff} * `CLRQ_CMD_ENTRY);
    wire        cmdEmpty = (cmdCons_ff == cmdProd_ff);
    wire        stsFull = (wrapInc(stsProd_ff, stsCount_ff) == stsCons_ff);
    wire        badCfg = (cmdCount_ff < 16'h0002) || (cmdCount_ff > `CLRQ_CMD_MAX)
                      || (stsCount_ff < 16'h0002) || (stsCount_ff > `CLRQ_STS_MAX);

    clrq_fifo #(
        .WIDTH (`CLRQ_FIFO_WIDTH),
        .DEPTH (`CLRQ_FIFO_DEPTH),
        .AW    (`CLRQ_FIFO_AW)
    ) cmdFifo (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .inData   (memRdata),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (!cmdValid_ff || cmdReady)
    );

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (startQueue) begin
                    nxt_state = S_CFG;
                end else if (running_ff && stsFill_ff == `CLRQ_STS_WORDS) begin
                    nxt_state = S_STSCON;
                end else if (running_ff && pending_ff) begin
                    nxt_state = S_PROD;
                end
            end
            S_CFG:    if (memAck && cfgStep_ff) nxt_state = S_IDLE;
            S_PROD:   if (memAck) nxt_state = S_FETCH;
            S_FETCH:  if (memAck && word_ff == `CLRQ_CMD_WORDS - 3'h1) nxt_state = S_CONS;
            S_CONS:   if (memAck) nxt_state = S_IDLE;
            S_STSCON: if (memAck) nxt_state = S_STSWR;
            S_STSWR:  if (memAck && word_ff == `CLRQ_STS_WORDS - 3'h1) nxt_state = S_STSIDX;
            S_STSIDX: if (memAck) nxt_state = S_IDLE;
            default:  nxt_state = S_IDLE;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= S_IDLE;
            base_ff     <= 32'h00000000;
            cmdCount_ff <= 16'h0000;
            stsCount_ff <= 16'h0000;
            cmdProd_ff  <= `CLRQ_IDX_RESET;
            cmdCons_ff  <= `CLRQ_IDX_RESET;
            stsProd_ff  <= `CLRQ_IDX_RESET;
            stsCons_ff  <= `CLRQ_IDX_RESET;
            word_ff     <= 3'h0;
            cfgStep_ff  <= 1'b0;
            pending_ff  <= 1'b0;
            running_ff  <= 1'b0;
            stsFill_ff  <= 3'h0;
            fifoLevel_ff <= 6'h00;
            outBeat_ff  <= 3'h0;
            memReq_ff   <= 1'b0;
            memWrite_ff <= 1'b0;
            memAddr_ff  <= 32'h00000000;
            memWdata_ff <= 32'h00000000;
            cmdWord_ff  <= 32'h00000000;
            cmdValid_ff <= 1'b0;
            cmdLast_ff  <= 1'b0;
            stsReady_ff <= 1'b0;
            busy_ff     <= 1'b0;
            stsFull_ff  <= 1'b0;
            cfgError_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state != S_IDLE);
            if (attnWrite && attnData == `CLRQ_ATTN_START) begin
                pending_ff <= 1'b1;
            end else if (state_ff == S_PROD && memAck && (memRdata[15:0] == cmdCons_ff || badCfg)) begin
                pending_ff <= 1'b0;
            end
            // status words arrive from the executing side; several per command allowed
            stsReady_ff <= (stsFill_ff < `CLRQ_STS_WORDS - 3'h1)
                        || ((stsFill_ff < `CLRQ_STS_WORDS) && !(stsValid && stsReady_ff));
            if (stsValid && stsReady_ff) begin
                stsBuf_ff[stsFill_ff[1:0]] <= stsWord;
                stsFill_ff <= stsFill_ff + 3'h1;
            end
            fifoLevel_ff <= fifoLevel_ff + {5'h00, fifoPush} - {5'h00, fifoPop};
            if (fifoPop) begin
                cmdWord_ff  <= fifoData;
                cmdValid_ff <= 1'b1;
                // last flag counted on the output side so it stays with its word
                cmdLast_ff  <= (outBeat_ff == `CLRQ_CMD_WORDS - 3'h1);
                outBeat_ff  <= (outBeat_ff == `CLRQ_CMD_WORDS - 3'h1) ? 3'h0 : outBeat_ff + 3'h1;
            end else if (cmdReady) begin
                cmdValid_ff <= 1'b0;
            end
            memReq_ff <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    word_ff <= 3'h0;
                    if (startQueue) begin
                        base_ff    <= {queueBase[31:2], 2'b00};
                        running_ff <= 1'b0;
                        cfgStep_ff <= 1'b0;
                        cmdCons_ff <= `CLRQ_IDX_RESET;
                        stsProd_ff <= `CLRQ_IDX_RESET;
                        memReq_ff  <= 1'b1;
                        memWrite_ff <= 1'b0;
                        memAddr_ff <= {queueBase[31:2], 2'b00} + `CLRQ_OFF_CMD_COUNT;
                    end else if (nxt_state == S_STSCON || nxt_state == S_PROD) begin
                        memReq_ff   <= 1'b1;
                        memWrite_ff <= 1'b0;
                        memAddr_ff  <= base_ff + ((nxt_state == S_PROD) ? `CLRQ_OFF_CMD_PROD
                                                                        : `CLRQ_OFF_STS_CONS);
                    end
                end
                S_CFG: begin
                    if (memAck && !cfgStep_ff) begin
                        cmdCount_ff <= memRdata[15:0];
                        cfgStep_ff  <= 1'b1;
                        memReq_ff   <= 1'b1;
                        memAddr_ff  <= base_ff + `CLRQ_OFF_STS_COUNT;
                    end else if (memAck) begin
                        stsCount_ff <= memRdata[15:0];
                        running_ff  <= 1'b1;
                        cfgError_ff <= cfgError_ff || (cmdCount_ff < 16'h0002) || (cmdCount_ff > `CLRQ_CMD_MAX)
                                    || (memRdata[15:0] < 16'h0002) || (memRdata[15:0] > `CLRQ_STS_MAX);
                    end
                end
                S_PROD: begin
                    if (memAck) begin
                        cmdProd_ff <= memRdata[15:0];
                        // fetch only when the fifo has room for a whole entry
                        if (memRdata[15:0] == cmdCons_ff || badCfg || !fifoInReady
                            || fifoLevel_ff > `CLRQ_FETCH_ROOM) begin
                            cfgError_ff <= cfgError_ff || badCfg;
                            state_ff    <= S_IDLE;
                        end else begin
                            memReq_ff <= 1'b1;
                            memAddr_ff <= entryAddr(cmdCons_ff, `CLRQ_CMD_ENTRY, cmdRing);
                        end
                    end
                end
                S_FETCH: begin
                    if (memAck) begin
                        word_ff <= word_ff + 3'h1;
                        memReq_ff <= 1'b1;
                        if (word_ff == `CLRQ_CMD_WORDS - 3'h1) begin
                            cmdCons_ff  <= wrapInc(cmdCons_ff, cmdCount_ff);
                            memWrite_ff <= 1'b1;
                            memAddr_ff  <= base_ff + `CLRQ_OFF_CMD_CONS;
                            memWdata_ff <= {16'h0000, wrapInc(cmdCons_ff, cmdCount_ff)};
                        end else begin
                            memAddr_ff <= memAddr_ff + 32'h00000004;
                        end
                    end
                end
                S_STSCON: begin
                    if (memAck) begin
                        stsCons_ff <= memRdata[15:0];
                        stsFull_ff <= (wrapInc(stsProd_ff, stsCount_ff) == memRdata[15:0]);
                        if (wrapInc(stsProd_ff, stsCount_ff) == memRdata[15:0]) begin
                            state_ff <= S_IDLE;
                        end else begin
                            memReq_ff   <= 1'b1;
                            memWrite_ff <= 1'b1;
                            memAddr_ff  <= entryAddr(stsProd_ff, `CLRQ_STS_ENTRY, stsRing);
                            memWdata_ff <= stsBuf_ff[0];
                        end
                    end
                end
                S_STSWR: begin
                    if (memAck) begin
                        word_ff   <= word_ff + 3'h1;
                        memReq_ff <= 1'b1;
                        if (word_ff == `CLRQ_STS_WORDS - 3'h1) begin
                            stsProd_ff  <= wrapInc(stsProd_ff, stsCount_ff);
                            memAddr_ff  <= base_ff + `CLRQ_OFF_STS_PROD;
                            memWdata_ff <= {16'h0000, wrapInc(stsProd_ff, stsCount_ff)};
                        end else begin
                            memAddr_ff  <= memAddr_ff + 32'h00000004;
                            memWdata_ff <= stsBuf_ff[word_ff[1:0] + 2'h1];
                        end
                    end
                end
                S_STSIDX: begin
                    if (memAck) begin
                        memWrite_ff <= 1'b0;
                        stsFill_ff  <= 3'h0;
                    end
                end
                default: begin
                    memWrite_ff <= 1'b0;
                end
            endcase
            if (state_ff == S_CONS && memAck) begin
                memWrite_ff <= 1'b0;
            end
        end
    end
endmodule

// [clrq_regs.vh]
// constants for the command list ring queue engine
// assumes byte addresses on a 32-bit host memory bus
`ifndef CLRQ_REGS_VH
`define CLRQ_REGS_VH
`define CLRQ_HDR_BYTES      32'h00000020
`define CLRQ_OFF_CMD_PROD   32'h00000000
`define CLRQ_OFF_CMD_CONS   32'h00000004
`define CLRQ_OFF_STS_PROD   32'h00000008
`define CLRQ_OFF_STS_CONS   32'h0000000C
`define CLRQ_OFF_CMD_COUNT  32'h00000010
`define CLRQ_OFF_STS_COUNT  32'h00000014
`define CLRQ_CMD_RING_OFF   32'h00000020
`define CLRQ_CMD_ENTRY      32'h0000001C
`define CLRQ_STS_ENTRY      32'h00000010
`define CLRQ_CMD_WORDS      3'h7
`define CLRQ_STS_WORDS      3'h4
`define CLRQ_CMD_MAX        16'h0924
`define CLRQ_STS_MAX        16'h1000
`define CLRQ_IDX_RESET      16'h0000
`define CLRQ_ATTN_START     32'h00000001
`define CLRQ_FIFO_WIDTH     32
`define CLRQ_FIFO_DEPTH     32
`define CLRQ_FIFO_AW        5
// highest fifo fill that still takes a whole command entry
`define CLRQ_FETCH_ROOM     6'h19
`endif

// [clrq_fifo.v]
// synchronous fifo holding fetched command words
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module clrq_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             ref_clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr_ff;
    reg [AW:0]      rdPtr_ff;
    wire            doWr = inValid && inReady;
    wire            doRd = outValid && outReady;
    assign inReady  = (wrPtr_ff[AW] == rdPtr_ff[AW]) || (wrPtr_ff[AW-1:0] != rdPtr_ff[AW-1:0]);
    assign outValid = wrPtr_ff != rdPtr_ff;
    assign outData  = mem[rdPtr_ff[AW-1:0]];
    always @(posedge ref_clk) begin
        if (doWr) begin
            mem[wrPtr_ff[AW-1:0]] <= inData;
        end
    end
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_ff <= {(AW+1){1'b0}};
            rdPtr_ff <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (doRd) begin
                rdPtr_ff <= rdPtr_ff + 1'b1;
            end
        end
    end
endmodule

// [clrq_engine_chk.sv]
// port checker for the ring queue engine
// assumes queueBase held steady while the queue runs
`timescale 1ns/1ps
module clrq_engine_chk (
    input wire        ref_clk,
    input wire        rst_n,
    input wire        startQueue,
    input wire [31:0] queueBase,
    input wire        attnWrite,
    input wire [31:0] attnData,
    input wire        memReq_ff,
    input wire        memWrite_ff,
    input wire [31:0] memAddr_ff,
    input wire [31:0] cmdWord_ff,
    input wire        cmdValid_ff,
    input wire        cmdLast_ff,
    input wire        cmdReady,
    input wire        busy_ff,
    input wire        cfgError_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire [31:0] base = {queueBase[31:2], 2'h0};
    wire        wr   = memReq_ff && memWrite_ff;
    wire        take = cmdValid_ff && cmdReady;
    reg  [2:0]  beat_ff;
    wire [2:0]  nxt_beat = cmdLast_ff ? 3'h0 : beat_ff + 3'h1;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            beat_ff <= 3'h0;
        end else if (take) begin
            beat_ff <= nxt_beat;
        end
    end
    chk_prod_untouched: assert property (wr |-> memAddr_ff != base)
        else $error("command producer index written");
    chk_scons_untouched: assert property (wr |-> memAddr_ff != base + 32'h0C)
        else $error("status consumer index written");
    chk_addr_aligned: assert property (memReq_ff |-> memAddr_ff[1:0] == 2'h0)
        else $error("unaligned memory address");
    chk_write_region: assert property (wr |-> memAddr_ff >= base + 32'h20 ||
        memAddr_ff == base + 32'h4 || memAddr_ff == base + 32'h8)
        else $error("write outside adapter owned words");
    chk_entry_beats: assert property (take |-> cmdLast_ff == (beat_ff == 3'h6))
        else $error("command entry not seven words");
    chk_word_hold: assert property (cmdValid_ff && !cmdReady |=>
        cmdValid_ff && $stable(cmdWord_ff) && $stable(cmdLast_ff))
        else $error("command word dropped while stalled");
    chk_attn_ignored: assert property (!busy_ff && attnWrite && attnData != 32'h1 &&
        !startQueue |=> !memReq_ff [*3])
        else $error("attention value other than one acted on");
    chk_cfg_sticky: assert property (cfgError_ff |=> cfgError_ff)
        else $error("config error flag cleared");
    cover property (take && cmdLast_ff);
    cover property (wr && memAddr_ff == base + 32'h4);
    cover property ($rose(cfgError_ff));
endmodule
bind clrq_engine clrq_engine_chk chk_u (.ref_clk, .rst_n, .startQueue, .queueBase, .attnWrite, .attnData,
    .memReq_ff, .memWrite_ff, .memAddr_ff, .cmdWord_ff, .cmdValid_ff, .cmdLast_ff, .cmdReady, .busy_ff,
    .cfgError_ff);

// [clrq_host_mem.sv]
// host memory model answering engine requests
// assumes one request outstanding at a time
`timescale 1ns/1ps
module clrq_host_mem #(
    parameter WORDS = 512
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        memReq_ff,
    input  wire        memWrite_ff,
    input  wire [31:0] memAddr_ff,
    input  wire [31:0] memWdata_ff,
    output reg  [31:0] memRdata,
    output reg         memAck
);
    reg  [31:0] mem [0:WORDS-1];
    integer     ackDelay;
    integer     waitCnt;
    reg         pend_ff;
    reg         wr_ff;
    reg  [31:0] addr_ff;
    reg  [31:0] data_ff;
    initial ackDelay = 0;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            memAck <= 1'b0;
            memRdata <= 32'h0;
            pend_ff <= 1'b0;
        end else begin
            memAck <= 1'b0;
            memRdata <= ~memRdata; // stale data toggles between answers
            if (memReq_ff) begin
                pend_ff <= 1'b1;
                wr_ff <= memWrite_ff;
                addr_ff <= memAddr_ff;
                data_ff <= memWdata_ff;
                waitCnt <= ackDelay;
            end else if (pend_ff && waitCnt > 0) begin
                waitCnt <= waitCnt - 1;
            end else if (pend_ff) begin
                memAck <= 1'b1;
                pend_ff <= 1'b0;
                if (wr_ff) mem[addr_ff[10:2]] <= data_ff;
                else memRdata <= mem[addr_ff[10:2]];
            end
        end
    end
endmodule

// [clrq_engine_tb.sv]
// self-checking bench for the ring queue engine
// assumes host memory model behind the memory port
`timescale 1ns/1ps
module clrq_engine_tb;
    localparam [31:0] BASE = 32'h00000100;
    localparam integer BW = 64;
    reg         ref_clk;
    reg         rst_n;
    reg         startQueue;
    reg         attnWrite;
    reg  [31:0] attnData;
    reg         cmdReady;
    reg  [31:0] stsWord;
    reg         stsValid;
    wire        memReq_ff, memWrite_ff, memAck, cmdValid_ff, cmdLast_ff, stsReady_ff, busy_ff, stsFull_ff;
    wire        cfgError_ff;
    wire [31:0] memAddr_ff, memWdata_ff, memRdata, cmdWord_ff;
    integer     miscompares;
    integer     n_compared;
    integer     i;
    clrq_engine dut_u (.queueBase(BASE), .*);
    clrq_host_mem host_u (.*);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task cmp(input [31:0] exp, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task final_report;
        begin
            if (miscompares == 0 && n_compared > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(negedge ref_clk);
        end
    endtask
    task bound(input integer k);
        begin
            if (k > 3000) begin
                miscompares = miscompares + 1;
                final_report;
            end
            tick(1);
        end
    endtask
    task wait_idle;
        integer k;
        begin
            tick(2);
            for (k = 0; busy_ff !== 1'b0; k = k + 1) bound(k);
        end
    endtask
    task do_reset;
        begin
            rst_n = 1'b0;
            tick(6);
            rst_n = 1'b1;
        end
    endtask
    task attn(input [31:0] v);
        begin
            attnData = v;
            attnWrite = 1'b1;
            tick(1);
            attnWrite = 1'b0;
        end
    endtask
    task setup(input [15:0] nCmd, input [15:0] nSts, input [15:0] prod);
        begin
            do_reset;
            for (i = 0; i < 72; i = i + 1) host_u.mem[BW + i] = (i < 8) ? 32'h0 : 32'hA4FFFFF8 + i;
            host_u.mem[BW + 4] = {16'h0, nCmd};
            host_u.mem[BW + 5] = {16'h0, nSts};
            startQueue = 1'b1;
            tick(1);
            startQueue = 1'b0;
            wait_idle;
            host_u.mem[BW] = {16'h0, prod};
        end
    endtask
    task get_cmd(input integer e);
        integer w;
        integer k;
        begin
            for (w = 0; w < 7; w = w + 1) begin
                for (k = 0; !(cmdValid_ff === 1'b1 && cmdReady === 1'b1); k = k + 1) bound(k);
                cmp(32'hA5000000 + e * 7 + w, cmdWord_ff);
                cmp(w == 6, cmdLast_ff);
                tick(1);
            end
        end
    endtask
    task push_sts(input [31:0] w0);
        integer w;
        integer k;
        begin
            stsValid = 1'b1;
            for (w = 0; w < 4; w = w + 1) begin
                stsWord = w0 + w;
                for (k = 0; stsReady_ff !== 1'b1; k = k + 1) bound(k);
                tick(1);
            end
            stsValid = 1'b0;
            // a full ring keeps the engine retrying, so the full flag also ends the wait
            tick(2);
            for (k = 0; busy_ff !== 1'b0 && stsFull_ff !== 1'b1; k = k + 1) bound(k);
        end
    endtask
    task check_cfg(input [15:0] nCmd, input [15:0] nSts, input e);
        begin
            setup(nCmd, nSts, 16'h0);
            cmp(e, cfgError_ff);
        end
    endtask
    task sc_counts;
        begin
            check_cfg(16'h0001, 16'h0008, 1'b1);
            check_cfg(16'h0008, 16'h0000, 1'b1);
            check_cfg(16'h0925, 16'h0008, 1'b1);
            check_cfg(16'h0008, 16'h1001, 1'b1);
            check_cfg(16'h0924, 16'h1000, 1'b0);
            check_cfg(16'h0002, 16'h0002, 1'b0);
        end
    endtask
    task sc_fetch;
        begin
            setup(16'h0003, 16'h0004, 16'h0001);
            attn(32'h00000002);
            tick(20);
            cmp(32'h0, cmdValid_ff);
            attn(32'h00000001);
            get_cmd(0);
            wait_idle;
            cmp(32'h1, host_u.mem[BW + 1]);
            cmp(32'h1, host_u.mem[BW]);
            host_u.ackDelay = 3;
            host_u.mem[BW] = 32'h0;
            attn(32'h00000001);
            get_cmd(1);
            get_cmd(2);
            wait_idle;
            cmp(32'h0, host_u.mem[BW + 1]);
            host_u.ackDelay = 0;
        end
    endtask
    task sc_fifo;
        begin
            setup(16'h0006, 16'h0004, 16'h0005);
            cmdReady = 1'b0;
            attn(32'h00000001);
            tick(400);
            cmp(32'h4, host_u.mem[BW + 1]);
            cmdReady = 1'b1;
            for (i = 0; i < 4; i = i + 1) get_cmd(i);
            cmdReady = 1'b0;
            wait_idle;
            attn(32'h00000001);
            cmdReady = 1'b1;
            get_cmd(4);
            wait_idle;
            cmp(32'h5, host_u.mem[BW + 1]);
        end
    endtask
    task sc_status;
        begin
            setup(16'h0003, 16'h0002, 16'h0000);
            push_sts(32'h5A000000);
            for (i = 0; i < 4; i = i + 1) cmp(32'h5A000000 + i, host_u.mem[BW + 29 + i]);
            cmp(32'h1, host_u.mem[BW + 2]);
            cmp(32'h0, stsFull_ff);
            push_sts(32'h5B000000);
            cmp(32'h1, stsFull_ff);
            cmp(32'h1, host_u.mem[BW + 2]);
            cmp(32'hA5000019, host_u.mem[BW + 33]);
        end
    endtask
    initial begin
        rst_n = 1'b0;
        startQueue = 1'b0;
        attnWrite = 1'b0;
        attnData = 32'h0;
        cmdReady = 1'b1;
        stsWord = 32'h0;
        stsValid = 1'b0;
        miscompares = 0;
        n_compared = 0;
        tick(6);
        cmp(32'h0, {memReq_ff, cmdValid_ff, busy_ff, cfgError_ff, stsReady_ff, stsFull_ff});
        rst_n = 1'b1;
        sc_counts;
        sc_fetch;
        sc_fifo;
        sc_status;
        final_report;
    end
endmodule
